/* swu_write_rx.sv */
// Single-wire UART write-datagram receiver with automatic bit-time measurement.
// Behaviour
// [R1] Each transmission opens with a sync nibble in byte one, then an address byte.
// [R2] Bytes carry a low start bit and a high stop bit.
// [R3] Bit time is measured from start-bit fall to fall between sync bits two and three.
// [R4] The bit timer re-locks on every datagram, tracking any valid host rate.
// [R5] Data moves byte-wise, the 32-bit word most significant byte first.
// [R6] Bits go LSB first per byte; the 64-bit datagram ends with its CRC byte.
// [R7] Datagram: node address, write flag plus register address, 32 data bits, CRC.
// [R8] Host keeps at least 9000 baud.
// [R9] Host keeps baud at or below clock divided by sixteen.
// [R10] Node address is the setting, plus one while the increment pin is high.
// [R11] The shared line is released whenever this party is not sending.
// [R12] CRC-8 polynomial x^8+x^2+x+1, zero start, LSB first, over all bytes before the CRC byte.
// [R13] Only valid own-address writes are taken; each bumps an 8-bit counter.
// [R14] Over 63 bit times between start bits resets; then 12 idle bit times.
// [R15] Data bits are sampled mid-period using the measured bit time.
`timescale 1ns/100ps
module swu_write_rx #(
    parameter int unsigned CNT_W = swu_pkg::SWU_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic single_wire_io_pos_in,
    output logic single_wire_io_pos_out,
    output logic single_wire_io_pos_oe_n,
    input wire logic [7:0] node_address_setting,
    input wire logic address_increment_pin,
    output logic [6:0] wr_reg_addr,
    output logic [31:0] wr_data,
    output logic wr_strobe,
    output logic [7:0] dgram_count,
    output logic frame_error
);
    import swu_pkg::*;

    swu_state_t state_q;
    logic line_q;
    logic fall;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] bit_time_q;
    logic [CNT_W-1:0] meas_q;
    logic [2:0] sync_falls_q;
    logic [2:0] bit_idx_q;
    logic [2:0] byte_idx_q;
    logic [7:0] shreg_q;
    logic [63:0] dgram_q;
    logic [7:0] node_addr_q;
    logic crc_clear;
    logic crc_bit_valid;
    logic crc_bit_in;
    logic [7:0] crc_val;
    logic [CNT_W-1:0] half_bit;
    logic [CNT_W+5:0] gap_limit;
    logic [CNT_W+3:0] rec_limit;
    logic [CNT_W+5:0] gap_q;
    logic [CNT_W+3:0] idle_q;
    logic sample_now;
    logic crc_ok;
    logic addr_ok;

    assign fall = line_q && !single_wire_io_pos_in;
    assign half_bit = bit_time_q >> 1;
    assign sample_now = (tmr_q == bit_time_q - 1'b1);
    assign gap_limit = bit_time_q * (CNT_W+6)'(SWU_TIMEOUT_BITS);
    assign rec_limit = bit_time_q * (CNT_W+4)'(SWU_RECOVER_BITS);
    assign crc_clear = (state_q == SWU_IDLE);
    // Sync bits 0..2 are only seen as edges, so the CRC takes them from the fixed
    // pattern during the first three cycles of the start bit. The CRC byte is not fed.
    assign crc_bit_in = (state_q == SWU_SYNC) ? SWU_SYNC_NIBBLE[meas_q[1:0]]
                                              : single_wire_io_pos_in;
    assign crc_bit_valid = ((state_q == SWU_BITS) && sample_now && byte_idx_q != 3'h7)
                           || ((state_q == SWU_SYNC) && sync_falls_q == 3'h0
                               && meas_q < (CNT_W)'(SWU_SYNC_BITS)); // [R12]
    assign crc_ok = (crc_val == shreg_q); // [R12]
    assign addr_ok = (dgram_q[47:40] == node_addr_q); // [R13]

    swu_crc8 u_crc (
        .clk(clk),
        .rst(rst),
        .clear(crc_clear),
        .bit_valid(crc_bit_valid),
        .bit_in(crc_bit_in),
        .crc(crc_val)
    );

    // The receiver never drives the line; the enable is held high at all times.
    always_ff @(posedge clk) begin
        single_wire_io_pos_out <= 1'b1;
        single_wire_io_pos_oe_n <= 1'b1; // [R11]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            line_q <= 1'b1;
        end else begin
            line_q <= single_wire_io_pos_in;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            node_addr_q <= SWU_NODE_ADDR_RST;
        end else begin
            node_addr_q <= node_address_setting + {7'h00, address_increment_pin}; // [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= SWU_IDLE;
            tmr_q <= '0;
            meas_q <= '0;
            bit_time_q <= '1;
            sync_falls_q <= '0;
            bit_idx_q <= '0;
            byte_idx_q <= '0;
            shreg_q <= 8'h00;
            dgram_q <= '0;
            gap_q <= '0;
            idle_q <= '0;
            wr_strobe <= 1'b0;
            wr_reg_addr <= 7'h00;
            wr_data <= 32'h00000000;
            dgram_count <= SWU_DGRAM_CNT_RST;
            frame_error <= 1'b0;
        end else begin
            wr_strobe <= 1'b0;
            frame_error <= 1'b0;
            gap_q <= gap_q + 1'b1;
            case (state_q)
                SWU_IDLE: begin
                    if (fall) begin
                        state_q <= SWU_SYNC;
                        meas_q <= '0;
                        sync_falls_q <= '0;
                        byte_idx_q <= '0;
                    end
                end
                SWU_SYNC: begin
                    meas_q <= meas_q + 1'b1;
                    if (fall) begin
                        sync_falls_q <= sync_falls_q + 1'b1;
                        // Start bit plus sync bits 0..2 span four bit times.
                        if (sync_falls_q == 3'h1) begin // [R3]
                            bit_time_q <= (meas_q + 1'b1) >> 2; // [R4]
                            tmr_q <= (meas_q + 1'b1) >> 3;
                            bit_idx_q <= 3'h3;
                            // Preset sync bits 0..2 so five shifts leave the nibble in [3:0].
                            shreg_q <= {SWU_SYNC_NIBBLE[2:0], 5'h00};
                            state_q <= SWU_BITS;
                        end
                    end
                    // A low start pulse of meas_q + 1 cycles below the limit is a glitch.
                    if (single_wire_io_pos_in && (meas_q + 1'b1) < (CNT_W)'(SWU_GLITCH_CYCLES)
                            && sync_falls_q == 3'h0 && !line_q) begin
                        state_q <= SWU_RECOVER;
                        idle_q <= '0;
                    end
                end
                SWU_BITS: begin
                    tmr_q <= sample_now ? '0 : tmr_q + 1'b1;
                    if (sample_now) begin // [R15]
                        shreg_q <= {single_wire_io_pos_in, shreg_q[7:1]}; // [R6]
                        bit_idx_q <= bit_idx_q + 1'b1;
                        if (bit_idx_q == 3'h7) begin
                            state_q <= SWU_STOP;
                        end
                    end
                end
                SWU_STOP: begin
                    tmr_q <= sample_now ? '0 : tmr_q + 1'b1;
                    if (sample_now) begin
                        if (!single_wire_io_pos_in) begin // [R2]
                            state_q <= SWU_RECOVER;
                            idle_q <= '0;
                        end else if (byte_idx_q == 3'h0 && shreg_q[3:0] != SWU_SYNC_NIBBLE) begin
                            state_q <= SWU_RECOVER; // [R1]
                            idle_q <= '0;
                        end else if (byte_idx_q == 3'(SWU_DGRAM_BYTES - 1)) begin
                            state_q <= SWU_IDLE;
                            if (crc_ok && addr_ok && dgram_q[39]) begin // [R7]
                                wr_strobe <= 1'b1;
                                wr_reg_addr <= dgram_q[38:32];
                                wr_data <= dgram_q[31:0]; // [R5]
                                dgram_count <= dgram_count + 1'b1; // [R13]
                            end else if (!crc_ok) begin
                                frame_error <= 1'b1;
                            end
                        end else begin
                            dgram_q <= {dgram_q[55:0], shreg_q};
                            byte_idx_q <= byte_idx_q + 1'b1;
                            state_q <= SWU_GAP;
                        end
                    end
                end
                SWU_GAP: begin
                    if (fall) begin
                        gap_q <= '0;
                        // Start half a bit below zero so the first sample is mid bit 0.
                        tmr_q <= '0 - half_bit; // [R15]
                        bit_idx_q <= '0;
                        shreg_q <= 8'h00;
                        state_q <= SWU_BITS;
                    end else if (gap_q > gap_limit) begin
                        state_q <= SWU_RECOVER; // [R14]
                        frame_error <= 1'b1;
                        idle_q <= '0;
                    end
                end
                SWU_RECOVER: begin
                    // Any low level restarts the idle count, so a noisy line stays locked out.
                    idle_q <= single_wire_io_pos_in ? idle_q + 1'b1 : '0;
                    if (idle_q >= rec_limit) begin
                        state_q <= SWU_IDLE; // [R14]
                    end
                end
                default: begin
                    state_q <= SWU_IDLE;
                end
            endcase
            if (state_q == SWU_IDLE || (state_q == SWU_SYNC && sync_falls_q == 3'h0)) begin
                gap_q <= '0;
            end
        end
    end
endmodule : swu_write_rx

/* swu_pkg.sv */
// Package with constants and types for the single-wire write receiver.
package swu_pkg;
    localparam int unsigned SWU_CLK_HZ = 10000000;
    localparam logic [3:0] SWU_SYNC_NIBBLE = 4'h5;
    localparam logic [7:0] SWU_CRC_POLY = 8'h07;
    localparam logic [7:0] SWU_CRC_INIT = 8'h00;
    localparam int unsigned SWU_DGRAM_BYTES = 8;
    localparam int unsigned SWU_SYNC_BITS = 3;
    localparam int unsigned SWU_TIMEOUT_BITS = 63;
    localparam int unsigned SWU_RECOVER_BITS = 12;
    localparam int unsigned SWU_GLITCH_CYCLES = 16;
    localparam int unsigned SWU_CNT_W = 20;
    localparam logic [7:0] SWU_NODE_ADDR_RST = 8'h00;
    localparam logic [7:0] SWU_DGRAM_CNT_RST = 8'h00;
    typedef enum logic [2:0] {
        SWU_IDLE,
        SWU_SYNC,
        SWU_BITS,
        SWU_STOP,
        SWU_GAP,
        SWU_RECOVER
    } swu_state_t;
endpackage : swu_pkg

/* swu_crc8.sv */
// Serial CRC-8 engine fed one bit per strobe, least significant bit first.
`timescale 1ns/100ps
module swu_crc8 (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic bit_valid,
    input wire logic bit_in,
    output logic [7:0] crc
);
    import swu_pkg::*;
    logic [7:0] crc_q;
    logic fb;
    assign fb = crc_q[7] ^ bit_in;
    assign crc = crc_q;
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            crc_q <= SWU_CRC_INIT;
        end else if (bit_valid) begin
            crc_q <= {crc_q[6:0], 1'b0} ^ (fb ? SWU_CRC_POLY : 8'h00); // [R12]
        end
    end
endmodule : swu_crc8

/* swu_write_rx_asserts.sv */
// Checker for the single-wire write receiver ports.
`timescale 1ns/100ps
module swu_write_rx_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic single_wire_io_pos_in,
    input wire logic single_wire_io_pos_out,
    input wire logic single_wire_io_pos_oe_n,
    input wire logic [6:0] wr_reg_addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_strobe,
    input wire logic [7:0] dgram_count,
    input wire logic frame_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A full datagram lasts 80 bit times, so no second event can follow within 8 cycles.
    sequence s_quiet;
        (!wr_strobe && !frame_error)[*8];
    endsequence
    sequence s_stop_seen;
        $past(single_wire_io_pos_in, 1) && $past(single_wire_io_pos_in, 4);
    endsequence
    a_line_released: assert property (single_wire_io_pos_oe_n && single_wire_io_pos_out)
        else $error("receiver drives the shared line");
    a_strobe_then_quiet: assert property (wr_strobe |=> s_quiet)
        else $error("write strobe not a lone pulse");
    a_error_then_quiet: assert property (frame_error |=> s_quiet)
        else $error("frame error not a lone pulse");
    a_strobe_after_stop: assert property (wr_strobe |-> s_stop_seen)
        else $error("write strobe without high stop level");
    a_count_steps_one: assert property ($changed(dgram_count) |->
        dgram_count == $past(dgram_count) + 8'h01) else $error("count jump is not one");
    a_count_on_strobe: assert property (wr_strobe |-> ##[0:1] $changed(dgram_count))
        else $error("count did not follow write strobe");
    a_data_on_strobe: assert property ($changed(wr_data) || $changed(wr_reg_addr) |->
        wr_strobe || $past(wr_strobe)) else $error("write data changed without strobe");
    a_no_both_pulses: assert property (!(wr_strobe && frame_error))
        else $error("strobe and frame error together");
endmodule : swu_write_rx_chk
bind swu_write_rx swu_write_rx_chk i_chk (
    .clk(clk),
    .rst(rst),
    .single_wire_io_pos_in(single_wire_io_pos_in),
    .single_wire_io_pos_out(single_wire_io_pos_out),
    .single_wire_io_pos_oe_n(single_wire_io_pos_oe_n),
    .wr_reg_addr(wr_reg_addr),
    .wr_data(wr_data),
    .wr_strobe(wr_strobe),
    .dgram_count(dgram_count),
    .frame_error(frame_error)
);

/* swu_host_model.sv */
// Host UART model that sends write datagrams onto the shared line.
`timescale 1ns/100ps
module swu_host_model (
    input wire logic clk,
    output logic line_drv
);
    initial line_drv = 1'b1;
    function automatic logic [7:0] crc8(input logic [55:0] b);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 6; k >= 0; k--) begin
            for (int j = 0; j < 8; j++) begin
                c = (c[7] ^ b[8*k+j]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction : crc8
    // Bit times of 16 or more keep the rate at or below a sixteenth of the clock.
    task automatic send_byte(input int bt, input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            line_drv = f[i];
            repeat (bt - 1) @(negedge clk);
        end
    endtask : send_byte
    // Drives a short low pulse that the receiver must treat as a glitch.
    task automatic pulse(input int n);
        @(negedge clk);
        line_drv = 1'b0;
        repeat (n) @(negedge clk);
        line_drv = 1'b1;
    endtask : pulse
    task automatic write(input int bt, input logic [7:0] nd, input logic [7:0] rr,
                         input logic [31:0] d, input logic [7:0] flip);
        logic [63:0] g;
        g = {8'h05, nd, rr, d, 8'h00};
        g[7:0] = crc8(g[63:8]) ^ flip;
        for (int k = 7; k >= 0; k--) send_byte(bt, g[8*k +: 8]);
    endtask : write
endmodule : swu_host_model

/* testbench.sv */
// Self-checking bench for the single-wire write receiver.
`timescale 1ns/100ps
module testbench;
    logic clk, rst, host_line, single_wire_io_pos_in, single_wire_io_pos_out;
    logic single_wire_io_pos_oe_n, address_increment_pin, wr_strobe, frame_error;
    logic [7:0] node_address_setting, dgram_count;
    logic [6:0] wr_reg_addr;
    logic [31:0] wr_data;
    logic [31:0] n_mismatch = '0, checks_done = '0, n_strobe = '0, n_err = '0;
    // The line is pulled high whenever neither party drives it.
    assign single_wire_io_pos_in = host_line & (single_wire_io_pos_oe_n | single_wire_io_pos_out);
    swu_write_rx i_dut (
        .clk(clk),
        .rst(rst),
        .single_wire_io_pos_in(single_wire_io_pos_in),
        .single_wire_io_pos_out(single_wire_io_pos_out),
        .single_wire_io_pos_oe_n(single_wire_io_pos_oe_n),
        .node_address_setting(node_address_setting),
        .address_increment_pin(address_increment_pin),
        .wr_reg_addr(wr_reg_addr),
        .wr_data(wr_data),
        .wr_strobe(wr_strobe),
        .dgram_count(dgram_count),
        .frame_error(frame_error)
    );
    swu_host_model i_host (.clk(clk), .line_drv(host_line));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (wr_strobe === 1'b1) n_strobe <= n_strobe + 1;
        if (frame_error === 1'b1) n_err <= n_err + 1;
    end
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    task automatic end_of_test;
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Sends one datagram, idles 13 bit times so recovery can finish, then judges it.
    task automatic xfer(input int bt, input logic [7:0] nd, input logic [7:0] rr,
                        input logic [31:0] d, input logic [7:0] flip, input int acc, input int err);
        logic [31:0] s0, e0;
        logic [7:0] c0;
        s0 = n_strobe;
        e0 = n_err;
        c0 = dgram_count;
        i_host.write(bt, nd, rr, d, flip);
        repeat (13 * bt) @(negedge clk);
        cmp("strobes", s0 + acc, n_strobe);
        cmp("errors", e0 + err, n_err);
        cmp("count", {24'h0, c0 + 8'(acc)}, {24'h0, dgram_count});
    endtask : xfer
    task automatic t_basic;
        xfer(16, 8'h3a, 8'h92, 32'hdeadbeef, 8'h00, 1, 0);
        cmp("reg", 32'h12, {25'h0, wr_reg_addr});
        cmp("data", 32'hdeadbeef, wr_data);
    endtask : t_basic
    task automatic t_relock_inc;
        address_increment_pin = 1'b1;
        xfer(40, 8'h3b, 8'hff, 32'h01020304, 8'h00, 1, 0);
        cmp("reg", 32'h7f, {25'h0, wr_reg_addr});
        cmp("data", 32'h01020304, wr_data);
    endtask : t_relock_inc
    task automatic t_refused;
        xfer(16, 8'h3a, 8'h85, 32'h11111111, 8'h00, 0, 0);
        xfer(24, 8'h3b, 8'h05, 32'h22222222, 8'h00, 0, 0);
        xfer(16, 8'h3b, 8'h85, 32'h33333333, 8'h01, 0, 1);
        cmp("data", 32'h01020304, wr_data);
        xfer(16, 8'h3b, 8'h85, 32'h44444444, 8'h00, 1, 0);
    endtask : t_refused
    task automatic t_gap;
        logic [31:0] e0;
        e0 = n_err;
        i_host.send_byte(16, 8'h05);
        i_host.send_byte(16, 8'h3b);
        repeat (90 * 16) @(negedge clk);
        cmp("gap errors", e0 + 1, n_err);
        xfer(16, 8'h3b, 8'h81, 32'h55aa55aa, 8'h00, 1, 0);
    endtask : t_gap
    // A glitch locks the receiver out until the line has idled 12 bit times.
    task automatic t_glitch;
        i_host.pulse(8);
        repeat (64) @(negedge clk);
        xfer(16, 8'h3b, 8'h83, 32'h66666666, 8'h00, 0, 0);
        xfer(16, 8'h3b, 8'h83, 32'h77777777, 8'h00, 1, 0);
        cmp("reg", 32'h03, {25'h0, wr_reg_addr});
        cmp("data", 32'h77777777, wr_data);
    endtask : t_glitch
    initial begin
        rst = 1'b1;
        address_increment_pin = 1'b0;
        node_address_setting = 8'h3a;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_basic();
        t_relock_inc();
        t_refused();
        t_gap();
        t_glitch();
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
endmodule : testbench
